// [hdl/aicp_pkg.sv]
// shared types and constants for the amplifier two-wire control port
package aicp_pkg;

  // ==========================================================
  // timing
  localparam int AICP_CLK_PERIOD_NS = 40;
  localparam int AICP_SPIKE_NS = 50;
  localparam int AICP_FILT_CYC_INT = (AICP_SPIKE_NS + AICP_CLK_PERIOD_NS - 1) / AICP_CLK_PERIOD_NS;
  localparam logic [3:0] AICP_FILT_CYC = 4'(AICP_FILT_CYC_INT);

  // ==========================================================
  // bus framing
  localparam logic [3:0] AICP_BYTE_BITS = 4'h8;
  localparam logic [3:0] AICP_LAST_BIT_RISE = 4'h7;
  localparam logic [6:0] AICP_ADDR_BASE = 7'h10;
  localparam logic [7:0] AICP_LAST_SUBADDR = 8'h2f;
  localparam logic [7:0] AICP_SUBADDR_RESET = 8'h00;
  localparam logic [7:0] AICP_BYTE_RESET = 8'h00;
  localparam logic [3:0] AICP_CNT_RESET = 4'h0;
  localparam logic [5:0] AICP_SLOT_ONE = 6'h01;

  // ==========================================================
  // strap pin states as resolved by the pin slicer
  typedef enum logic [2:0] {
    AICP_STRAP_GND  = 3'h0,
    AICP_STRAP_VDD  = 3'h1,
    AICP_STRAP_PD   = 3'h2,
    AICP_STRAP_PU   = 3'h3,
    AICP_STRAP_OPEN = 3'h4
  } aicp_strap_t;

  typedef struct packed {
    logic [6:0] addr;
    logic standalone;
    logic [5:0] slot_first;
    logic [5:0] slot_second;
    logic [5:0] slot_mono;
  } aicp_cfg_t;

  localparam aicp_cfg_t AICP_CFG_RESET = '{addr: 7'h10, standalone: 1'b0, slot_first: 6'h01,
                                           slot_second: 6'h02, slot_mono: 6'h01};

  typedef struct packed {
    logic scl;
    logic sda;
  } aicp_bus_t;

  localparam aicp_bus_t AICP_BUS_IDLE = '{scl: 1'b1, sda: 1'b1};

  // ==========================================================
  // controller states, gray along the write path
  typedef enum logic [3:0] {
    AICP_IDLE      = 4'h0,
    AICP_ADDR      = 4'h1,
    AICP_ADDR_ACK  = 4'h3,
    AICP_SUB       = 4'h2,
    AICP_SUB_ACK   = 4'h6,
    AICP_WDATA     = 4'h7,
    AICP_WDATA_ACK = 4'h5,
    AICP_RDATA     = 4'hd,
    AICP_RDATA_ACK = 4'hc
  } aicp_state_t;

  // pin tied through a resistor, either way
  function automatic logic aicp_strap_weak(input aicp_strap_t s);
    aicp_strap_weak = (s == AICP_STRAP_PD) || (s == AICP_STRAP_PU);
  endfunction : aicp_strap_weak

  // pin at the supply side, hard or weak
  function automatic logic aicp_strap_high(input aicp_strap_t s);
    aicp_strap_high = (s == AICP_STRAP_VDD) || (s == AICP_STRAP_PU);
  endfunction : aicp_strap_high

  function automatic logic aicp_strap_open(input aicp_strap_t s);
    aicp_strap_open = !((s == AICP_STRAP_GND) || (s == AICP_STRAP_VDD) || aicp_strap_weak(s));
  endfunction : aicp_strap_open

endpackage : aicp_pkg

// [hdl/aicp_line_filter.sv]
// synchroniser and spike filter for the two bus lines
`timescale 1ns/1ps
`default_nettype none
module aicp_line_filter (
  input wire logic clock,
  input wire logic rstn,
  input wire aicp_pkg::aicp_bus_t raw,
  output aicp_pkg::aicp_bus_t clean
);
  import aicp_pkg::*;

  logic [1:0] raw_v;
  logic [1:0] clean_v;

  assign raw_v = {raw.scl, raw.sda};
  assign clean = '{scl: clean_v[1], sda: clean_v[0]};

  // ==========================================================
  // per line: two flops, then hold until stable for the spike time
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_line
      logic meta;
      logic sync;
      logic level;
      logic [3:0] run;

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta <= 1'b1;
          sync <= 1'b1;
        end else begin
          meta <= raw_v[g];
          sync <= meta;
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          level <= 1'b1;
          run <= AICP_CNT_RESET;
        end else if (sync == level) begin
          run <= AICP_CNT_RESET;
        end else if (run + 4'h1 >= AICP_FILT_CYC) begin
          level <= sync;
          run <= AICP_CNT_RESET;
        end else begin
          run <= run + 4'h1;
        end
      end

      assign clean_v[g] = level;
    end
  endgenerate

endmodule : aicp_line_filter
`default_nettype wire

// [hdl/aicp_top.sv]
// two-wire control target port with strap decode for the amplifier
`timescale 1ns/1ps
`default_nettype none
module aicp_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire aicp_pkg::aicp_strap_t strap_pin_a,
  input wire aicp_pkg::aicp_strap_t strap_pin_b,
  input wire logic slot_sel_load,
  input wire logic [5:0] slot_sel_value,
  output aicp_pkg::aicp_cfg_t strap_cfg,
  output logic strap_valid,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  import aicp_pkg::*;

  // ==========================================================
  // line conditioning and bus events
  aicp_bus_t raw_bus;
  aicp_bus_t cur;
  aicp_bus_t prev;

  assign raw_bus = '{scl: scl_in, sda: sda_in};

  aicp_line_filter u_filter (
    .clock(clock),
    .rstn(rstn),
    .raw(raw_bus),
    .clean(cur)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev <= AICP_BUS_IDLE;
    end else begin
      prev <= cur;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = cur.scl && !prev.scl;
  assign scl_fall = !cur.scl && prev.scl;
  // start is data falling under a high clock
  assign start_seen = cur.scl && prev.scl && prev.sda && !cur.sda && !strap_cfg.standalone;
  // stop is data rising under a high clock
  assign stop_seen = cur.scl && prev.scl && !prev.sda && cur.sda;

  // ==========================================================
  // strap capture
  logic [3:0] strap_idx;
  aicp_cfg_t strap_dec;

  // five resolved levels, unknown codes count as open
  // weak bits select the address group, level bits the entry
  assign strap_idx = {aicp_strap_weak(strap_pin_a), aicp_strap_weak(strap_pin_b),
                      aicp_strap_high(strap_pin_a), aicp_strap_high(strap_pin_b)};

  always_comb begin
    strap_dec.addr = AICP_ADDR_BASE | {3'h0, strap_idx};
    strap_dec.standalone = aicp_strap_open(strap_pin_a) || aicp_strap_open(strap_pin_b);
    // stereo pair and mono slot from the same index
    strap_dec.slot_first = {1'b0, strap_idx, 1'b0} + AICP_SLOT_ONE;
    strap_dec.slot_second = {1'b0, strap_idx, 1'b0} + AICP_SLOT_ONE + AICP_SLOT_ONE;
    strap_dec.slot_mono = {2'h0, strap_idx} + AICP_SLOT_ONE;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_valid <= 1'b0;
      strap_cfg <= AICP_CFG_RESET;
    end else if (!strap_valid) begin
      strap_valid <= 1'b1;
      strap_cfg <= strap_dec;
    end else if (slot_sel_load) begin
      strap_cfg.slot_first <= slot_sel_value;
      strap_cfg.slot_second <= slot_sel_value + AICP_SLOT_ONE;
      strap_cfg.slot_mono <= slot_sel_value;
    end
  end

  // ==========================================================
  // transfer controller
  aicp_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic dir_read;
  logic over;
  logic byte_done;
  logic addr_match;
  logic sub_ok;
  logic ack_now;

  assign byte_done = scl_fall && (bit_cnt == AICP_BYTE_BITS);
  // upper seven bits are the target address
  assign addr_match = (shift[7:1] == strap_cfg.addr) && strap_valid && !strap_cfg.standalone;
  assign sub_ok = (shift <= AICP_LAST_SUBADDR);

  always_comb begin
    case (state)
      AICP_ADDR: ack_now = addr_match;
      AICP_SUB: ack_now = sub_ok;
      AICP_WDATA: ack_now = !over;
      default: ack_now = 1'b0;
    endcase
  end

  // only the data line has a driver, and only in answer to the master
  // the pad value is a constant low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= AICP_IDLE;
      bit_cnt <= AICP_CNT_RESET;
      shift <= AICP_BYTE_RESET;
      dir_read <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      // start or repeated start from any state
      state <= AICP_ADDR;
      bit_cnt <= AICP_CNT_RESET;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state <= AICP_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        AICP_ADDR, AICP_SUB, AICP_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], cur.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= AICP_CNT_RESET;
            if (state == AICP_ADDR) begin
              dir_read <= shift[0];
            end
            if (ack_now) begin
              // hold data low through the ninth clock
              sda_oe <= 1'b1;
              case (state)
                AICP_ADDR: state <= AICP_ADDR_ACK;
                AICP_SUB: state <= AICP_SUB_ACK;
                default: state <= AICP_WDATA_ACK;
              endcase
            end else begin
              state <= AICP_IDLE;
            end
          end
        end
        AICP_ADDR_ACK, AICP_SUB_ACK, AICP_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            bit_cnt <= AICP_CNT_RESET;
            if (state == AICP_ADDR_ACK && dir_read) begin
              // read, data turns round to the device
              state <= AICP_RDATA;
              shift <= reg_rdata;
              sda_oe <= !reg_rdata[7];
            end else if (state == AICP_ADDR_ACK) begin
              state <= AICP_SUB;
            end else begin
              state <= AICP_WDATA;
            end
          end
        end
        AICP_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == AICP_BYTE_BITS) begin
              sda_oe <= 1'b0;
              state <= AICP_RDATA_ACK;
            end else begin
              // a one is sent by releasing the line
              shift <= {shift[6:0], 1'b0};
              sda_oe <= !shift[6];
            end
          end
        end
        AICP_RDATA_ACK: begin
          if (scl_rise && cur.sda) begin
            state <= AICP_IDLE;
          end else if (scl_fall) begin
            state <= AICP_RDATA;
            bit_cnt <= AICP_CNT_RESET;
            shift <= reg_rdata;
            sda_oe <= !reg_rdata[7];
          end
        end
        default: begin
          // idle only leaves on a start
          state <= AICP_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // subaddress pointer and register strobes
  logic sub_take;
  logic wr_take;
  logic rd_last_rise;

  assign sub_take = !start_seen && !stop_seen && state == AICP_SUB && byte_done && sub_ok;
  assign wr_take = !start_seen && !stop_seen && state == AICP_WDATA && byte_done && !over;
  assign rd_last_rise = !start_seen && !stop_seen && state == AICP_RDATA && scl_rise
                        && bit_cnt == AICP_LAST_BIT_RISE;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_addr <= AICP_SUBADDR_RESET;
      reg_wdata <= AICP_BYTE_RESET;
      reg_wr <= 1'b0;
      over <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      if (sub_take) begin
        reg_addr <= shift;
        over <= 1'b0;
      end else if (wr_take) begin
        reg_wr <= 1'b1;
        reg_wdata <= shift;
        // step on, or mark the pointer as past the end
        if (reg_addr == AICP_LAST_SUBADDR) begin
          over <= 1'b1;
        end else begin
          reg_addr <= reg_addr + 8'h01;
        end
      end else if (rd_last_rise && reg_addr != AICP_LAST_SUBADDR) begin
        // reads stop stepping at the highest register
        reg_addr <= reg_addr + 8'h01;
      end
    end
  end

  // ==========================================================
  // checks
  chk_data_never_high: assert property (@(posedge clock) disable iff (!rstn)
    sda_out == 1'b0) else $error("data pad driven high");

  chk_ack_on_match: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_ADDR && byte_done && addr_match && !start_seen && !stop_seen)
      |=> (sda_oe && state == AICP_ADDR_ACK)) else $error("matched address not acknowledged");

  chk_mismatch_release: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_ADDR && byte_done && !addr_match && !start_seen && !stop_seen)
      |=> (!sda_oe && state == AICP_IDLE)) else $error("foreign address not released");

  chk_start_restart: assert property (@(posedge clock) disable iff (!rstn)
    start_seen |=> (state == AICP_ADDR && bit_cnt == AICP_CNT_RESET && !sda_oe))
    else $error("start not taken");

  chk_stop_idle: assert property (@(posedge clock) disable iff (!rstn)
    (stop_seen && !start_seen) |=> (state == AICP_IDLE && !sda_oe)) else $error("stop not taken");

  chk_bad_subaddr: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_SUB && byte_done && !sub_ok && !start_seen && !stop_seen)
      |=> (state == AICP_IDLE && !sda_oe)) else $error("invalid subaddress acknowledged");

  chk_write_overflow: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_WDATA && byte_done && over && !start_seen && !stop_seen)
      |=> (!reg_wr && !sda_oe && state == AICP_IDLE)) else $error("overflow byte accepted");

  chk_read_hold_top: assert property (@(posedge clock) disable iff (!rstn)
    (rd_last_rise && reg_addr == AICP_LAST_SUBADDR) |=> (reg_addr == AICP_LAST_SUBADDR))
    else $error("read pointer passed the top");

  chk_write_advance: assert property (@(posedge clock) disable iff (!rstn)
    (wr_take && reg_addr != AICP_LAST_SUBADDR)
      |=> (reg_wr && reg_addr == $past(reg_addr) + 8'h01)) else $error("burst write did not advance");

  chk_read_direction: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_ADDR_ACK && scl_fall && dir_read && !start_seen && !stop_seen)
      |=> state == AICP_RDATA) else $error("read direction not honoured");

  chk_strap_once: assert property (@(posedge clock) disable iff (!rstn)
    strap_valid |=> ($stable(strap_cfg.addr) && $stable(strap_cfg.standalone)))
    else $error("strap address changed after capture");

  chk_drive_in_answer: assert property (@(posedge clock) disable iff (!rstn)
    sda_oe |-> (state inside {AICP_ADDR_ACK, AICP_SUB_ACK, AICP_WDATA_ACK, AICP_RDATA}))
    else $error("data line pulled outside an answer");

  chk_good_subaddr: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_SUB && byte_done && sub_ok && !start_seen && !stop_seen)
      |=> (sda_oe && state == AICP_SUB_ACK && reg_addr == $past(shift)))
    else $error("valid subaddress not taken");

  chk_nack_ends_read: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_RDATA_ACK && scl_rise && cur.sda && !start_seen && !stop_seen)
      |=> (state == AICP_IDLE && !sda_oe)) else $error("read went on after a nack");

  chk_read_release: assert property (@(posedge clock) disable iff (!rstn)
    (state == AICP_RDATA && scl_fall && bit_cnt == AICP_BYTE_BITS && !start_seen && !stop_seen)
      |=> (!sda_oe && state == AICP_RDATA_ACK)) else $error("data line held into master acknowledge");

  chk_standalone_quiet: assert property (@(posedge clock) disable iff (!rstn)
    (strap_valid && strap_cfg.standalone) |-> (state == AICP_IDLE && !sda_oe))
    else $error("standalone port left idle");

  chk_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_take |=> (reg_wr && reg_wdata == $past(shift))) else $error("written byte not presented");

endmodule : aicp_top
`default_nettype wire

// [tb/aicp_bus_master.sv]
// behavioural two-wire bus master for the control port
`timescale 1ns/1ps
`default_nettype none
module aicp_bus_master (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 10;
  logic spike;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    spike = 1'b0;
  end
  // ==========================================================
  // line phases
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic start();
    tick(3);
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(3);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask : stop
  // one-cycle clock spike when asked, below the filter span
  task automatic bit_x(input logic b, output logic r);
    tick(3);
    sda_low = !b;
    tick(4);
    if (spike) begin
      scl = 1'b1;
      tick(1);
      scl = 1'b0;
    end
    tick(HALF);
    scl = 1'b1;
    tick(HALF / 2);
    r = sda;
    tick(HALF / 2);
    scl = 1'b0;
  endtask : bit_x
  // ==========================================================
  // bytes
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    a = !r;
  endtask : wbyte
  // ack the byte when am is set, nack it when am is clear
  task automatic rbyte(input logic am, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!am, r);
  endtask : rbyte
endmodule : aicp_bus_master
`default_nettype wire

// [tb/test_aicp_top.sv]
// self-checking bench for the two-wire control port
`timescale 1ns/1ps
`default_nettype none
module test_aicp_top;
  import aicp_pkg::*;
  typedef struct packed {
    aicp_strap_t a;
    aicp_strap_t b;
    aicp_cfg_t cfg;
  } aicp_row_t;
  localparam aicp_row_t ROWS [5] = '{
    '{AICP_STRAP_GND, AICP_STRAP_GND, '{7'h10, 1'b0, 6'h01, 6'h02, 6'h01}},
    '{AICP_STRAP_GND, AICP_STRAP_VDD, '{7'h11, 1'b0, 6'h03, 6'h04, 6'h02}},
    '{AICP_STRAP_VDD, AICP_STRAP_PD, '{7'h16, 1'b0, 6'h0d, 6'h0e, 6'h07}},
    '{AICP_STRAP_PD, AICP_STRAP_VDD, '{7'h19, 1'b0, 6'h13, 6'h14, 6'h0a}},
    '{AICP_STRAP_PU, AICP_STRAP_PU, '{7'h1f, 1'b0, 6'h1f, 6'h20, 6'h10}}};
  logic clock, rstn, slot_sel_load, sda_oe, sda_out, strap_valid, reg_wr, scl, sda_low, ack;
  logic [5:0] slot_sel_value;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic [6:0] dev;
  aicp_strap_t strap_pin_a, strap_pin_b;
  aicp_cfg_t strap_cfg;
  wire logic sda;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] wq [$];
  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    rd_exp = {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction : rd_exp
  assign reg_rdata = rd_exp(reg_addr);
  assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
  aicp_top uut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b), .slot_sel_load(slot_sel_load),
    .slot_sel_value(slot_sel_value), .strap_cfg(strap_cfg), .strap_valid(strap_valid),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));
  aicp_bus_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clock = 1'b0;
    forever #20 clock = !clock;
  end
  // ==========================================================
  // compares and monitors
  task automatic check1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask : check1
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask : check8
  task automatic check_cfg(input aicp_cfg_t g, input aicp_cfg_t e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask : check_cfg
  always @(negedge clock) begin
    if (reg_wr === 1'b1) begin
      wq.push_back(reg_wdata);
    end
  end
  always @(negedge clock) begin
    if (sda_oe === 1'b1) begin
      check1(sda_out, 1'b0);
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ==========================================================
  // transfers
  task automatic wb(input logic [7:0] d, input logic e);
    m.wbyte(d, ack);
    check1(ack, e);
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic am);
    m.rbyte(am, got);
    check8(got, e);
  endtask : rb
  task automatic hdr(input logic [7:0] sub);
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb(sub, 1'b1);
  endtask : hdr
  task automatic do_reset(input aicp_strap_t a, input aicp_strap_t b);
    strap_pin_a = a;
    strap_pin_b = b;
    rstn = 1'b0;
    m.tick(5);
    check1(sda_oe, 1'b0);
    check1(reg_wr, 1'b0);
    check1(strap_valid, 1'b0);
    check8(reg_addr, AICP_SUBADDR_RESET);
    check_cfg(strap_cfg, AICP_CFG_RESET);
    rstn = 1'b1;
    m.tick(8);
    check1(strap_valid, 1'b1);
  endtask : do_reset
  initial begin
    #2000000;
    num_errors++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    strap_pin_a = AICP_STRAP_GND;
    strap_pin_b = AICP_STRAP_GND;
    slot_sel_load = 1'b0;
    slot_sel_value = 6'h00;
    dev = 7'h10;
    for (int i = 0; i < 5; i++) begin
      do_reset(ROWS[i].a, ROWS[i].b);
      check_cfg(strap_cfg, ROWS[i].cfg);
      dev = ROWS[i].cfg.addr;
      m.start();
      wb({dev ^ 7'h01, 1'b0}, 1'b0);
      wb({dev, 1'b0}, 1'b0);
      m.stop();
      hdr(8'h01);
      m.stop();
    end
    wq.delete();
    hdr(8'h05);
    wb(8'ha1, 1'b1);
    wb(8'hb2, 1'b1);
    m.stop();
    check8(8'(wq.size()), 8'h02);
    check8(wq[0], 8'ha1);
    check8(wq[1], 8'hb2);
    check8(reg_addr, 8'h07);
    hdr(8'h05);
    m.start();
    wb({dev, 1'b1}, 1'b1);
    rb(rd_exp(8'h05), 1'b1);
    rb(rd_exp(8'h06), 1'b0);
    m.stop();
    m.start();
    wb({dev, 1'b1}, 1'b1);
    rb(rd_exp(8'h07), 1'b0);
    m.stop();
    m.start();
    wb({dev, 1'b0}, 1'b1);
    wb(AICP_LAST_SUBADDR + 8'h01, 1'b0);
    wb(8'h55, 1'b0);
    m.stop();
    wq.delete();
    hdr(AICP_LAST_SUBADDR - 8'h01);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b0);
    wb(8'h44, 1'b0);
    m.stop();
    check8(8'(wq.size()), 8'h02);
    hdr(AICP_LAST_SUBADDR - 8'h01);
    m.start();
    wb({dev, 1'b1}, 1'b1);
    rb(rd_exp(AICP_LAST_SUBADDR - 8'h01), 1'b1);
    rb(rd_exp(AICP_LAST_SUBADDR), 1'b1);
    rb(rd_exp(AICP_LAST_SUBADDR), 1'b0);
    m.stop();
    wq.delete();
    hdr(8'h03);
    for (int i = 0; i < 4; i++) begin
      m.bit_x(1'b0, ack);
    end
    m.stop();
    m.start();
    for (int i = 0; i < 3; i++) begin
      m.bit_x(1'b1, ack);
    end
    m.spike = 1'b1;
    hdr(8'h03);
    wb(8'h44, 1'b1);
    m.spike = 1'b0;
    m.stop();
    check8(8'(wq.size()), 8'h01);
    check8(wq[0], 8'h44);
    slot_sel_value = 6'h05;
    slot_sel_load = 1'b1;
    m.tick(1);
    slot_sel_load = 1'b0;
    m.tick(1);
    check_cfg(strap_cfg, aicp_cfg_t'{dev, 1'b0, 6'h05, 6'h06, 6'h05});
    do_reset(AICP_STRAP_OPEN, AICP_STRAP_GND);
    check1(strap_cfg.standalone, 1'b1);
    m.start();
    wb({AICP_ADDR_BASE, 1'b0}, 1'b0);
    m.stop();
    do_reset(AICP_STRAP_GND, aicp_strap_t'(3'h6));
    check1(strap_cfg.standalone, 1'b1);
    final_report();
  end
endmodule : test_aicp_top
`default_nettype wire
